// file: rtl/asu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module asu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("asu_fifo depth must be a power of two");
  end

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_reg];

  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + AW'(1);
      if (pop)
        rd_reg <= rd_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // asu_fifo
`default_nettype wire

// file: rtl/asu_pkg.sv
package asu_pkg;
  localparam logic [1:0] ASU_SCALE_X1 = 2'h0;
  localparam logic [1:0] ASU_SCALE_X16 = 2'h1;
  localparam logic [1:0] ASU_SCALE_X32 = 2'h2;
  localparam logic [1:0] ASU_SCALE_X64 = 2'h3;
  localparam logic [6:0] ASU_DIV_X16 = 7'h10;
  localparam logic [6:0] ASU_DIV_X32 = 7'h20;
  localparam logic [6:0] ASU_DIV_X64 = 7'h40;
  localparam logic [3:0] ASU_BASE_BITS = 4'h5;
  localparam logic [7:0] ASU_RX_DATA_RST = 8'hFF;
  localparam int ASU_FIFO_DEPTH = 4;

  typedef struct packed {
    logic [1:0] char_len;
    logic parity_en;
    logic parity_even;
    logic [1:0] clk_scale;
    logic clk_sel_timer;
  } asu_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } asu_rx_word_t;
endpackage : asu_pkg

// file: rtl/asu_uart.sv
// Function
// - five to eight bits, parity options, independent
// - one or two stop bits, break
// - recheck low half bit later, except in x1
// - framing error delays next search half bit, except in x1
// - clock from timer input or output
// - divide input clock by 1/16/32/64
// - idle transmit line held high
// - send break holds line low
// - auto start, parity, stop framing
// - unused upper transmit bits ignored
// - transmit changes on scaled clock fall
// - receiver starts only when enabled
// - sample each bit at mid-bit
// - x1 mode samples rising clock edge
// - received byte: data, parity, ones
// - one holding buffer with error flags
// - detect parity, framing, overrun errors
// - errors request interrupt when enabled
// - parity/overrun sticky until status write
// - reading data clears character available
// - buffer empty flag high when empty
// - scale code 00/01/10/11 gives 1/16/32/64
// - length code 00..11 gives 5..8 bits
`timescale 1ns/1ps
`default_nettype none
module asu_uart
  import asu_pkg::*;
#(
  parameter int FIFO_DEPTH = ASU_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire asu_cfg_t cfg_i,
  input wire logic two_stop_i,
  input wire logic tx_en_i,
  input wire logic brk_i,
  input wire logic rx_en_i,
  input wire logic rx_ie_i,
  input wire logic timer_in_i,
  input wire logic timer_out_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  output logic tx_empty_o,
  input wire logic rx_read_i,
  input wire logic status_wr_i,
  output logic [7:0] rx_data_o,
  output logic rx_avail_o,
  output logic parity_err_o,
  output logic frame_err_o,
  output logic overrun_err_o,
  output logic rx_err_o,
  output logic rx_irq_o,
  input wire logic rxd_i,
  output logic txd_o
);
  typedef enum logic [2:0] {ASU_TX_IDLE, ASU_TX_START, ASU_TX_DATA,
    ASU_TX_PAR, ASU_TX_STOP} asu_tx_state_t;
  typedef enum logic [2:0] {ASU_RX_IDLE, ASU_RX_START, ASU_RX_DATA,
    ASU_RX_PAR, ASU_RX_STOP, ASU_RX_HOLD} asu_rx_state_t;

  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("asu_uart fifo depth too small");
  end

  function automatic logic [3:0] bits_of(input logic [1:0] len);
    bits_of = ASU_BASE_BITS + {2'h0, len};
  endfunction

  // three-stage synchronisers; change accepted when stages 2 and 3 agree
  logic [2:0] clk_sync_reg;
  logic [2:0] rxd_sync_reg;
  logic uclk_reg;
  logic rxd_reg;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      clk_sync_reg <= 3'h0;
      rxd_sync_reg <= 3'h7;
      uclk_reg <= 1'b0;
      rxd_reg <= 1'b1;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0],
        cfg_i.clk_sel_timer ? timer_out_i : timer_in_i};
      rxd_sync_reg <= {rxd_sync_reg[1:0], rxd_i};
      if (clk_sync_reg[1] == clk_sync_reg[2])
        uclk_reg <= clk_sync_reg[2];
      if (rxd_sync_reg[1] == rxd_sync_reg[2])
        rxd_reg <= rxd_sync_reg[2];
    end
  end

  logic uclk_q_reg;
  logic uclk_rise;
  logic uclk_fall;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      uclk_q_reg <= 1'b0;
    else
      uclk_q_reg <= uclk_reg;
  end

  assign uclk_rise = uclk_reg && !uclk_q_reg;
  assign uclk_fall = !uclk_reg && uclk_q_reg;

  logic [6:0] div_n;
  always_comb
  begin
    unique case (cfg_i.clk_scale)
      ASU_SCALE_X1: div_n = 7'h01;
      ASU_SCALE_X16: div_n = ASU_DIV_X16;
      ASU_SCALE_X32: div_n = ASU_DIV_X32;
      ASU_SCALE_X64: div_n = ASU_DIV_X64;
    endcase
  end

  // transmit bit clock: divide input falling edges by div_n
  logic [6:0] tdiv_reg;
  logic tx_tick;
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      tdiv_reg <= 7'h00;
    else if (uclk_fall)
      tdiv_reg <= (tdiv_reg + 7'h01 >= div_n) ? 7'h00 : tdiv_reg + 7'h01;
  end
  assign tx_tick = uclk_fall && (tdiv_reg + 7'h01 >= div_n);

  // transmit buffer
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  asu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  assign tx_empty_o = !f_valid && tx_ready_o;

  asu_tx_state_t tx_st_reg;
  logic [7:0] tsh_reg;
  logic [3:0] tcnt_reg;
  logic tpar_reg;
  logic tline_reg;

  assign f_ready = (tx_st_reg == ASU_TX_IDLE) && tx_en_i && tx_tick;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      tx_st_reg <= ASU_TX_IDLE;
      tsh_reg <= 8'h00;
      tcnt_reg <= 4'h0;
      tpar_reg <= 1'b0;
      tline_reg <= 1'b1;
    end
    else if (tx_tick)
    begin
      unique case (tx_st_reg)
        ASU_TX_IDLE:
        begin
          tline_reg <= 1'b1;
          if (f_valid && tx_en_i)
          begin
            tsh_reg <= f_data;
            tpar_reg <= !cfg_i.parity_even;
            tcnt_reg <= 4'h0;
            tline_reg <= 1'b0;
            tx_st_reg <= ASU_TX_START;
          end
        end
        ASU_TX_START, ASU_TX_DATA:
        begin
          // only the configured low bits reach the line
          tline_reg <= tsh_reg[0];
          tpar_reg <= tpar_reg ^ tsh_reg[0];
          tsh_reg <= {1'b0, tsh_reg[7:1]};
          tcnt_reg <= tcnt_reg + 4'h1;
          tx_st_reg <= ASU_TX_DATA;
          if (tcnt_reg + 4'h1 == bits_of(cfg_i.char_len))
            tx_st_reg <= cfg_i.parity_en ? ASU_TX_PAR : ASU_TX_STOP;
          if (tcnt_reg + 4'h1 == bits_of(cfg_i.char_len))
            tcnt_reg <= 4'h0;
        end
        ASU_TX_PAR:
        begin
          tline_reg <= tpar_reg;
          tx_st_reg <= ASU_TX_STOP;
        end
        ASU_TX_STOP:
        begin
          tline_reg <= 1'b1;
          tcnt_reg <= tcnt_reg + 4'h1;
          if (tcnt_reg == {3'h0, two_stop_i})
            tx_st_reg <= ASU_TX_IDLE;
        end
      endcase
    end
  end

  // break overrides the line at once, regardless of the shifter
  assign txd_o = tline_reg && !brk_i;

  // receiver
  asu_rx_state_t rx_st_reg;
  logic [6:0] rdiv_reg;
  logic [6:0] half_n;
  logic [3:0] rcnt_reg;
  logic [7:0] rsh_reg;
  logic rpar_reg;
  logic rx_tick;
  logic rx_half;

  assign half_n = {1'b0, div_n[6:1]};
  // x1: external party supplies a bit-synchronous clock
  assign rx_tick = (cfg_i.clk_scale == ASU_SCALE_X1) ? uclk_rise
    : (uclk_rise && rdiv_reg + 7'h01 >= div_n);
  assign rx_half = uclk_rise && rdiv_reg + 7'h01 >= half_n;

  asu_rx_word_t hold_reg;
  logic avail_reg;
  logic pe_reg;
  logic fe_reg;
  logic ove_reg;
  logic done;
  logic done_pe;
  logic done_fe;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      rx_st_reg <= ASU_RX_IDLE;
      rdiv_reg <= 7'h00;
      rcnt_reg <= 4'h0;
      rsh_reg <= ASU_RX_DATA_RST;
      rpar_reg <= 1'b0;
    end
    else
    begin
      if (uclk_rise)
        rdiv_reg <= rx_tick ? 7'h00 : rdiv_reg + 7'h01;
      unique case (rx_st_reg)
        ASU_RX_IDLE:
        begin
          rdiv_reg <= 7'h00;
          // x1 has no recheck, so a start is only taken at a sampling edge
          if (rx_en_i && !rxd_reg
            && (rx_tick || cfg_i.clk_scale != ASU_SCALE_X1))
          begin
            rsh_reg <= ASU_RX_DATA_RST;
            rpar_reg <= !cfg_i.parity_even;
            rcnt_reg <= 4'h0;
            rx_st_reg <= (cfg_i.clk_scale == ASU_SCALE_X1)
              ? ASU_RX_DATA : ASU_RX_START;
          end
        end
        ASU_RX_START:
        begin
          if (rx_half)
          begin
            rdiv_reg <= 7'h00;
            rx_st_reg <= rxd_reg ? ASU_RX_IDLE : ASU_RX_DATA;
          end
        end
        ASU_RX_DATA:
        begin
          if (rx_tick)
          begin
            rsh_reg[rcnt_reg[2:0]] <= rxd_reg;
            rpar_reg <= rpar_reg ^ rxd_reg;
            rcnt_reg <= rcnt_reg + 4'h1;
            if (rcnt_reg + 4'h1 == bits_of(cfg_i.char_len))
              rx_st_reg <= cfg_i.parity_en ? ASU_RX_PAR : ASU_RX_STOP;
          end
        end
        ASU_RX_PAR:
        begin
          if (rx_tick)
          begin
            // parity kept in the byte unless eight data bits
            if (rcnt_reg != 4'h8)
              rsh_reg[rcnt_reg[2:0]] <= rxd_reg;
            rpar_reg <= rpar_reg ^ rxd_reg;
            rx_st_reg <= ASU_RX_STOP;
          end
        end
        ASU_RX_STOP:
        begin
          if (rx_tick)
          begin
            rdiv_reg <= 7'h00;
            rx_st_reg <= rxd_reg ? ASU_RX_IDLE : ASU_RX_HOLD;
          end
        end
        ASU_RX_HOLD:
        begin
          if (rx_half || cfg_i.clk_scale == ASU_SCALE_X1)
            rx_st_reg <= ASU_RX_IDLE;
        end
        default: rx_st_reg <= ASU_RX_IDLE;
      endcase
    end
  end

  assign done = (rx_st_reg == ASU_RX_STOP) && rx_tick;
  assign done_fe = !rxd_reg;
  assign done_pe = cfg_i.parity_en && rpar_reg;

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      hold_reg <= '{data: ASU_RX_DATA_RST, parity_err: 1'b0,
        frame_err: 1'b0};
      avail_reg <= 1'b0;
    end
    else if (done)
    begin
      hold_reg <= '{data: rsh_reg, parity_err: done_pe,
        frame_err: done_fe};
      avail_reg <= 1'b1;
    end
    else if (rx_read_i)
      avail_reg <= 1'b0;
  end

  // set wins over the clearing write
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      ove_reg <= 1'b0;
    end
    else
    begin
      if (done && done_pe)
        pe_reg <= 1'b1;
      else if (status_wr_i)
        pe_reg <= 1'b0;
      if (done && done_fe)
        fe_reg <= 1'b1;
      else if (status_wr_i)
        fe_reg <= 1'b0;
      if (done && avail_reg && !rx_read_i)
        ove_reg <= 1'b1;
      else if (status_wr_i)
        ove_reg <= 1'b0;
    end
  end

  assign rx_data_o = hold_reg.data;
  assign rx_avail_o = avail_reg;
  assign parity_err_o = pe_reg;
  assign frame_err_o = fe_reg;
  assign overrun_err_o = ove_reg;
  assign rx_err_o = pe_reg || fe_reg || ove_reg;
  assign rx_irq_o = rx_ie_i && (rx_err_o || avail_reg);
endmodule // asu_uart
`default_nettype wire

// file: test/asu_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module asu_serial_peer (
  input wire logic mclk_i,
  output logic uclk_o,
  output logic tmr_o,
  output logic rxd_o
);
  // timer source at half rate so the clock select shows in bit length
  initial
  begin
    uclk_o = 1'h0;
    tmr_o = 1'h0;
    rxd_o = 1'h1;
    #1;
    fork
      forever #16 uclk_o = ~uclk_o;
      forever #32 tmr_o = ~tmr_o;
    join
  end
  // idle line marks high between frames
  task automatic send(input logic [11:0] f, input int n, input int bt);
    // launch just after an input clock fall: x1 needs bit-synchronous data
    @(negedge uclk_o);
    @(posedge mclk_i);
    for (int i = 0; i < n; i++)
    begin
      rxd_o <= f[i];
      repeat (bt) @(posedge mclk_i);
    end
    rxd_o <= 1'h1;
  endtask
endmodule // asu_serial_peer
`default_nettype wire

// file: test/asu_uart_bench.sv
`timescale 1ns/1ps
`default_nettype none
module asu_uart_bench;
  import asu_pkg::*;
  logic mclk_i, nrst_i, two_stop_i, tx_en_i, brk_i, rx_en_i, rx_ie_i;
  logic tx_valid_i, rx_read_i, status_wr_i, timer_in_i, timer_out_i, rxd_i;
  logic tx_ready_o, tx_empty_o, rx_avail_o, parity_err_o, frame_err_o;
  logic overrun_err_o, rx_err_o, rx_irq_o, txd_o;
  logic [7:0] tx_data_i, rx_data_o, exp_rx;
  asu_cfg_t cfg_i;
  int error_cnt, compares, nb, bt;
  asu_uart asu_uart_inst (.*);
  asu_serial_peer asu_serial_peer_inst (.mclk_i, .uclk_o(timer_in_i),
    .tmr_o(timer_out_i), .rxd_o(rxd_i));
  initial
  begin
    mclk_i = 1'h0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] frame(input logic [7:0] d, input logic bad,
    input logic stop);
    logic [11:0] f;
    int k;
    logic p;
    f = '1;
    f[0] = 1'h0;
    k = cfg_i.char_len + 5;
    p = !cfg_i.parity_even ^ bad;
    for (int i = 0; i < k; i++)
    begin
      f[i+1] = d[i];
      p ^= d[i];
    end
    k++;
    if (cfg_i.parity_en)
    begin
      f[k] = p;
      k++;
    end
    f[k] = stop;
    nb = k + 1 + int'(two_stop_i);
    exp_rx = f[8:1];
    return f;
  endfunction
  task automatic cfgs(input int len, input int sc, input int p, input int e,
    input int s, input int t);
    cfg_i <= '{len[1:0], p[0], e[0], sc[1:0], t[0]};
    two_stop_i <= s[0];
    bt = (sc == 0) ? (8 << t) : (8 << (sc + 3 + t));
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic put(input logic [7:0] d);
    chk(tx_ready_o, 1'h1);
    tx_valid_i <= 1'h1;
    tx_data_i <= d;
    @(posedge mclk_i);
    tx_valid_i <= 1'h0;
  endtask
  task automatic grab(input logic [11:0] f);
    int w;
    w = 0;
    while (txd_o !== 1'h0 && w < 3000)
    begin
      @(posedge mclk_i);
      w++;
    end
    repeat (bt / 2) @(posedge mclk_i);
    for (int i = 0; i < nb; i++)
    begin
      chk(txd_o, f[i]);
      // end at mid last stop so a queued frame's start edge is seen
      if (i < nb - 1)
        repeat (bt) @(posedge mclk_i);
    end
  endtask
  // a bit of idle after each frame clears the framing-error holdoff
  task automatic rxget(input logic [7:0] d, input logic bad, input logic stop);
    logic [11:0] f;
    f = frame(d, bad, stop);
    asu_serial_peer_inst.send(f, nb, bt);
    repeat (bt) @(posedge mclk_i);
  endtask
  task automatic rdout();
    rx_read_i <= 1'h1;
    @(posedge mclk_i);
    rx_read_i <= 1'h0;
    @(posedge mclk_i);
    chk(rx_avail_o, 1'h0);
  endtask
  task automatic clrst();
    status_wr_i <= 1'h1;
    @(posedge mclk_i);
    status_wr_i <= 1'h0;
    @(posedge mclk_i);
    chk({parity_err_o, overrun_err_o}, 2'h0);
  endtask
  task automatic t_reset();
    chk({txd_o, tx_empty_o}, 2'h3);
    chk(rx_data_o, ASU_RX_DATA_RST);
    chk({rx_avail_o, rx_err_o, rx_irq_o}, 3'h0);
  endtask
  task automatic t_tx();
    for (int i = 0; i < 4; i++)
    begin
      cfgs(i, i % 3 + 1, i != 0, i / 2, i % 2, i / 3);
      put(8'ha5 ^ 8'(i));
      grab(frame(8'ha5 ^ 8'(i), 1'h0, 1'h1));
      repeat (bt) @(posedge mclk_i);
      chk(txd_o, 1'h1);
    end
  endtask
  task automatic t_fifo();
    cfgs(3, 1, 0, 0, 0, 0);
    tx_en_i <= 1'h0;
    tx_valid_i <= 1'h1;
    for (int i = 0; i < ASU_FIFO_DEPTH; i++)
    begin
      tx_data_i <= 8'(i);
      @(posedge mclk_i);
    end
    tx_valid_i <= 1'h0;
    @(posedge mclk_i);
    chk({tx_ready_o, tx_empty_o, txd_o}, 3'h1);
    tx_en_i <= 1'h1;
    for (int i = 0; i < ASU_FIFO_DEPTH; i++)
      grab(frame(8'(i), 1'h0, 1'h1));
    chk(tx_empty_o, 1'h1);
  endtask
  task automatic t_brk();
    put(8'hff);
    repeat (bt * 3) @(posedge mclk_i);
    brk_i <= 1'h1;
    repeat (bt * 5) @(posedge mclk_i);
    chk(txd_o, 1'h0);
    brk_i <= 1'h0;
    repeat (bt * 4) @(posedge mclk_i);
    chk(txd_o, 1'h1);
  endtask
  task automatic t_rx();
    rx_en_i <= 1'h1;
    rx_ie_i <= 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      cfgs(i, i % 3 + 1, i != 0, i / 2, i % 2, i / 3);
      rxget(8'h5a ^ 8'(i), 1'h0, 1'h1);
      chk({rx_avail_o, rx_irq_o, rx_err_o}, 3'h6);
      chk(rx_data_o, exp_rx);
      rdout();
    end
  endtask
  task automatic t_spike();
    asu_serial_peer_inst.send(12'h000, 1, bt / 4);
    repeat (bt * 12) @(posedge mclk_i);
    chk(rx_avail_o, 1'h0);
  endtask
  task automatic t_err();
    cfgs(3, 1, 1, 1, 0, 0);
    rxget(8'h3c, 1'h1, 1'h1);
    chk({parity_err_o, rx_err_o}, 2'h3);
    rdout();
    chk(parity_err_o, 1'h1);
    clrst();
    cfgs(3, 1, 0, 0, 0, 0);
    rxget(8'h81, 1'h0, 1'h0);
    chk({frame_err_o, rx_irq_o}, 2'h3);
    chk(rx_data_o, 8'h81);
    rdout();
    clrst();
    rxget(8'h01, 1'h0, 1'h1);
    rxget(8'h02, 1'h0, 1'h1);
    chk(overrun_err_o, 1'h1);
    rdout();
    clrst();
  endtask
  task automatic t_x1();
    cfgs(3, 0, 1, 1, 0, 0);
    put(8'h96);
    grab(frame(8'h96, 1'h0, 1'h1));
    rxget(8'h69, 1'h0, 1'h1);
    chk({rx_avail_o, rx_err_o}, 2'h2);
    chk(rx_data_o, exp_rx);
    rdout();
  endtask
  task automatic t_off();
    rx_en_i <= 1'h0;
    rxget(8'h11, 1'h0, 1'h1);
    chk(rx_avail_o, 1'h0);
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #400_000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    {nrst_i, two_stop_i, brk_i, rx_en_i, rx_ie_i} = '0;
    {tx_valid_i, rx_read_i, status_wr_i, tx_data_i, cfg_i} = '0;
    tx_en_i = 1'h1;
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'h1;
    @(posedge mclk_i);
    t_reset();
    t_tx();
    t_fifo();
    t_brk();
    t_rx();
    t_spike();
    t_err();
    t_x1();
    t_off();
    give_verdict();
  end
endmodule // asu_uart_bench
`default_nettype wire

// file: test/asu_uart_props.sv
`timescale 1ns/1ps
`default_nettype none
module asu_uart_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic brk_i,
  input wire logic rx_ie_i,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic tx_empty_o,
  input wire logic rx_read_i,
  input wire logic status_wr_i,
  input wire logic rx_avail_o,
  input wire logic parity_err_o,
  input wire logic frame_err_o,
  input wire logic overrun_err_o,
  input wire logic rx_err_o,
  input wire logic rx_irq_o,
  input wire logic txd_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  property p_brk_low;
    brk_i |-> !txd_o;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("line high in break");
  property p_err_or;
    rx_err_o == (parity_err_o | frame_err_o | overrun_err_o);
  endproperty
  a_err_or: assert property (p_err_or) else $error("error summary wrong");
  property p_irq;
    rx_irq_o == (rx_ie_i & (rx_err_o | rx_avail_o));
  endproperty
  a_irq: assert property (p_irq) else $error("rx request wrong");
  property p_rd_clr;
    rx_read_i |=> !rx_avail_o;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("avail kept");
  property p_pe_hold;
    parity_err_o && !status_wr_i |=> parity_err_o;
  endproperty
  a_pe_hold: assert property (p_pe_hold) else $error("parity flag lost");
  property p_ov_hold;
    overrun_err_o && !status_wr_i |=> overrun_err_o;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overrun lost");
  property p_empty_rdy;
    tx_empty_o |-> tx_ready_o;
  endproperty
  a_empty_rdy: assert property (p_empty_rdy) else $error("empty not ready");
  property p_push;
    tx_valid_i && tx_ready_o |=> !tx_empty_o;
  endproperty
  a_push: assert property (p_push) else $error("empty after write");
endmodule // asu_uart_props
bind asu_uart asu_uart_props asu_uart_props_inst (.*);
`default_nettype wire
